// ===== testbench/arsr_remote_tx.sv
// Remote asynchronous transmitter model driving the serial line
`timescale 1ns/1ps
module arsr_remote_tx #(
  parameter int BIT_CYC = 16
) (
  input wire logic sys_clk, // System clock
  output logic line // Serial line, idle high
);
  // Idle line stays high between frames, as with a pull-up
  initial line = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // One frame: start low, data LSB first, optional ninth bit, stop level
  task automatic send(input logic [7:0] d, input logic nine, input logic b9, input logic stop);
    int n;
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if (i == 0) line <= 1'b0;
      else if (i < 9) line <= d[i-1];
      else if (nine && i == 9) line <= b9;
      else line <= stop; // Low stop only when a scenario asks for it
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    line <= 1'b1;
    // A full idle bit, so the next start edge is clean
    repeat (BIT_CYC) @(posedge sys_clk);
  endtask : send
endmodule : arsr_remote_tx

// ===== testbench/testbench.sv
// Self-checking testbench of the asynchronous serial receiver
`timescale 1ns/1ps
module testbench import arsr_pkg::*;;
  logic sys_clk;
  logic nrst;
  logic pin;
  arsr_bus_t bus;
  logic [7:0] rd_data;
  logic rx_irq;
  logic [7:0] v;
  int errors;
  int checks;

  arsr_receiver i_arsr_receiver (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .bus(bus),
    .rd_data(rd_data),
    .serial_input_pin(pin),
    .rx_irq(rx_irq)
  );
  // Divisor 0 gives 16 system clocks per bit
  arsr_remote_tx #(.BIT_CYC(16)) i_arsr_remote_tx (
    .sys_clk(sys_clk),
    .line(pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Bus cycles, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
  endtask : wr

  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    checks++;
    if (rd_data !== e) begin
      errors++;
      $display("unexpected %0t: addr %h read %h want %h", $time, a, rd_data, e);
    end
  endtask : chk

  task automatic cmp1(input logic e);
    #1;
    checks++;
    if (rx_irq !== e) begin
      errors++;
      $display("unexpected %0t: irq %b want %b", $time, rx_irq, e);
    end
  endtask : cmp1

  task automatic frame(input logic [7:0] d, input logic nine, input logic b9, input logic stop);
    i_arsr_remote_tx.send(d, nine, b9, stop);
  endtask : frame

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk(8'h13, 8'h00);
    chk(8'h17, 8'h00);
    wr(8'h20, 8'hFF);
    chk(8'h20, 8'h00);
    wr(8'h17, 8'h00);
    wr(8'h1A, 8'h00);
    wr(8'h13, 8'hA0);
    frame(8'h3C, 1'b0, 1'b0, 1'b1);
    wr(8'h0F, 8'h01);
    chk(8'h16, 8'h00);
  endtask : t_reset

  // Clocked mode or a cleared port enable keeps the receiver deaf
  task automatic t_mode;
    wr(8'h13, 8'h90);
    wr(8'h1A, 8'h01);
    chk(8'h1A, 8'h01);
    frame(8'h5A, 1'b0, 1'b0, 1'b1);
    wr(8'h0F, 8'h01);
    chk(8'h16, 8'h00);
    wr(8'h0F, 8'h00);
    wr(8'h1A, 8'h00);
    wr(8'h13, 8'h10);
    frame(8'h6B, 1'b0, 1'b0, 1'b1);
    wr(8'h0F, 8'h01);
    chk(8'h16, 8'h00);
    wr(8'h0F, 8'h00);
    wr(8'h13, 8'h90);
    frame(8'hC3, 1'b0, 1'b0, 1'b1);
    chk(8'h13, 8'h90);
    chk(8'h14, 8'hC3);
  endtask : t_mode

  task automatic t_single;
    wr(8'h0F, 8'h00);
    wr(8'h13, 8'h90);
    frame(8'hA5, 1'b0, 1'b0, 1'b1);
    wr(8'h0F, 8'h01);
    chk(8'h16, 8'h01);
    chk(8'h13, 8'h00);
    chk(8'h0F, 8'h01);
    cmp1(1'b0);
    wr(8'h17, 8'h01);
    repeat (2) @(posedge sys_clk);
    cmp1(1'b1);
    wr(8'h16, 8'h00);
    chk(8'h16, 8'h01);
    wr(8'h0F, 8'h00);
    chk(8'h13, 8'h90);
    chk(8'h14, 8'hA5);
    wr(8'h0F, 8'h01);
    chk(8'h16, 8'h00);
    cmp1(1'b0);
  endtask : t_single

  // Third word with a full FIFO overruns; overrun then blocks pushes
  task automatic t_overrun;
    wr(8'h0F, 8'h00);
    frame(8'h11, 1'b0, 1'b0, 1'b1);
    frame(8'h22, 1'b0, 1'b0, 1'b1);
    frame(8'h33, 1'b0, 1'b0, 1'b1);
    chk(8'h13, 8'h92);
    chk(8'h14, 8'h11);
    chk(8'h14, 8'h22);
    frame(8'h44, 1'b0, 1'b0, 1'b1);
    wr(8'h0F, 8'h01);
    chk(8'h16, 8'h00);
    wr(8'h0F, 8'h00);
    wr(8'h13, 8'h80);
    chk(8'h13, 8'h80);
    wr(8'h13, 8'h90);
    frame(8'h55, 1'b0, 1'b0, 1'b1);
    chk(8'h14, 8'h55);
  endtask : t_overrun

  // Status bits travel with their own word
  task automatic t_status;
    wr(8'h13, 8'hD0);
    frame(8'h66, 1'b1, 1'b1, 1'b0);
    frame(8'h77, 1'b1, 1'b0, 1'b1);
    chk(8'h13, 8'hD5);
    chk(8'h14, 8'h66);
    chk(8'h13, 8'hD0);
    chk(8'h14, 8'h77);
  endtask : t_status

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // Watchdog well beyond some 2000 cycles of traffic
  initial begin
    #100000;
    errors++;
    final_report();
  end

  // Main sequence
  initial begin
    errors = 0;
    checks = 0;
    nrst = 1'b0;
    bus = '0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_single();
    t_overrun();
    t_status();
    t_mode();
    final_report();
  end
endmodule : testbench

// ===== verilog/arsr_pkg.sv
// Shared constants and types of the asynchronous serial receiver
package arsr_pkg;
  // Register locations; 10h..17h are banked by the bank selector
  localparam logic [7:0] OFS_BANK_SEL = 8'h0F;
  localparam logic [7:0] OFS_RX_STATUS = 8'h13;
  localparam logic [7:0] OFS_RX_DATA = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h16;
  localparam logic [7:0] OFS_BAUD = 8'h17;
  localparam logic [7:0] OFS_IRQ_EN = 8'h17;
  localparam logic [7:0] OFS_MODE = 8'h1A;
  localparam logic [7:0] BANKED_LO = 8'h10;
  localparam logic [7:0] BANKED_HI = 8'h17;
  localparam logic [3:0] BANK_RX = 4'h0;
  localparam logic [3:0] BANK_INT = 4'h1;
  // Field positions of the receive status/control, flag, interrupt enable and mode registers
  localparam int RCS_SERIAL_PORT_ENABLE = 7;
  localparam int RCS_RX9 = 6;
  localparam int RCS_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RCS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RCS_FRAMING_ERROR = 2;
  localparam int RCS_OVERRUN_ERROR = 1;
  localparam int RCS_NINTH_RECEIVED_BIT = 0;
  localparam int FLAG_RX = 0;
  localparam int IE_RX = 0;
  localparam int MODE_SYNC = 0;
  // Reset values
  localparam logic [7:0] RST_BANK = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_RD_DATA = 8'h00;
  // Oversampling timing in x16 ticks counted from 0, last data bit indices, FIFO full count
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_FIRST = 4'h6;
  localparam logic [3:0] SAMPLE_LAST = 4'h8;
  localparam logic [3:0] PHASE_END = 4'hF;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [1:0] FIFO_FULL = 2'h2;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_START = 2'b01, ST_DATA = 2'b11, ST_STOP = 2'b10} arsr_state_t;
  typedef enum logic [2:0] {
    SEL_NONE, SEL_BANK, SEL_STATUS, SEL_DATA, SEL_FLAGS, SEL_BAUD, SEL_IRQ_EN, SEL_MODE
  } arsr_sel_t;
  typedef struct packed {logic framing_error; logic ninth; logic [7:0] data;} arsr_word_t;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic wr; logic rd;} arsr_bus_t;
  typedef struct packed {
    logic [7:0] bank;
    logic serial_port_enable, rx9, single_receive_enable, continuous_receive_enable, overrun_error, sync_mode, receive_interrupt_enable;
    logic [7:0] baud;
    logic [7:0] div;
    logic [3:0] phase;
    logic [1:0] smp;
    logic rx_prev;
    arsr_state_t state;
    logic [3:0] bitcnt;
    logic [8:0] shifter;
    arsr_word_t [1:0] fifo;
    logic head;
    logic [1:0] count;
    logic [7:0] rd_data;
    logic irq;
  } arsr_regs_t;
endpackage : arsr_pkg

// ===== verilog/arsr_receiver.sv
// Asynchronous serial receiver with two-deep receive FIFO and banked registers
// Notes on behaviour
// - Bits recovered by a x16 oversampler; shifter advances once per bit.
// - Reception starts only while continuous receive enable is set.
// - At mid-stop, the shifted word goes into the FIFO if room.
// - A word entering the FIFO sets the receive flag.
// - Interrupt raised only while receive flag and its enable are both set.
// - Receive flag is read-only; clears when FIFO read empty.
// - FIFO holds two words while a third shifts; reads in arrival order.
// - Stop bit of third word with FIFO full sets overrun; word dropped.
// - Dropping continuous receive enable with single receive enable clear resets logic and clears overrun.
// - While overrun is set, no word enters the FIFO.
// - Framing error set when the stop bit is not high.
// - Framing error and ninth bit travel with each word; read advances them.
// - Each bit level is a majority of three pin samples.
// - Samples are taken on oversampling ticks seven, eight and nine.
// - Oversampling clock restarts on each start edge; sample group repeats every 16 ticks.
// - Nine-bit select adds a ninth data bit, shown as ninth received bit.
// - Clearing both receive enables or port enable resets receive logic.
// - Locations 10h..17h are banked; all others ignore the bank.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module arsr_receiver import arsr_pkg::*; (
  input wire logic sys_clk, // 200 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire arsr_bus_t bus, // Register bus request
  output logic [7:0] rd_data, // Read data, cycle after read strobe
  input wire logic serial_input_pin, // Serial data from remote transmitter
  output logic rx_irq // Receive interrupt request
);

  arsr_regs_t s;
  arsr_regs_t n;
  arsr_sel_t sel;
  logic rx_run;
  logic rx_keep;
  logic tick;
  logic vote;
  logic pop;
  logic push;
  logic stop_done;
  logic [3:0] last_bit;
  arsr_word_t head_word;
  arsr_word_t new_word;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, honouring the bank only inside the banked window
  function automatic arsr_sel_t reg_decode(input logic [7:0] addr, input logic [3:0] bank);
    arsr_sel_t r;
    r = SEL_NONE;
    if (addr >= BANKED_LO && addr <= BANKED_HI) begin
      if (bank == BANK_RX) begin
        if (addr == OFS_RX_STATUS) r = SEL_STATUS;
        else if (addr == OFS_RX_DATA) r = SEL_DATA;
        else if (addr == OFS_BAUD) r = SEL_BAUD;
      end else if (bank == BANK_INT) begin
        if (addr == OFS_FLAGS) r = SEL_FLAGS;
        else if (addr == OFS_IRQ_EN) r = SEL_IRQ_EN;
      end
    end else if (addr == OFS_BANK_SEL) begin
      r = SEL_BANK;
    end else if (addr == OFS_MODE) begin
      r = SEL_MODE;
    end
    return r;
  endfunction : reg_decode

  // Two of three agree
  function automatic logic majority(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : majority

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    n = s;
    sel = reg_decode(bus.addr, s.bank[3:0]);
    // Async mode only; clocked mode select holds the receiver off
    rx_run = s.serial_port_enable & ~s.sync_mode & s.continuous_receive_enable;
    rx_keep = s.serial_port_enable & (s.continuous_receive_enable | s.single_receive_enable);
    last_bit = s.rx9 ? LAST_BIT_9 : LAST_BIT_8;
    head_word = s.fifo[s.head];
    new_word.data = s.rx9 ? s.shifter[7:0] : s.shifter[8:1];
    new_word.ninth = s.rx9 & s.shifter[8];
    new_word.framing_error = 1'b0;
    // x16 tick, restarted at a start edge; divisor+1 system clocks per tick
    tick = (s.div == 8'h00);
    n.div = tick ? s.baud : s.div - 8'h01;
    if (tick) begin
      n.phase = s.phase + 4'h1;
    end
    // Three samples on ticks 7, 8 and 9 of each bit; the third is live
    if (tick && s.phase >= SAMPLE_FIRST && s.phase < SAMPLE_LAST) begin
      n.smp = {s.smp[0], serial_input_pin};
    end
    vote = majority(s.smp[1], s.smp[0], serial_input_pin);
    stop_done = 1'b0;
    push = 1'b0;
    n.rx_prev = serial_input_pin;

    // Receive sequencer
    unique case (s.state)
      ST_IDLE: begin
        if (rx_run && s.rx_prev && !serial_input_pin) begin
          n.state = ST_START;
          n.phase = 4'h0;
          n.div = s.baud;
        end
      end
      ST_START: begin
        if (tick && s.phase == SAMPLE_LAST && vote) begin
          n.state = ST_IDLE; // Glitch, not a real start bit
        end else if (tick && s.phase == PHASE_END) begin
          n.state = ST_DATA;
          n.bitcnt = 4'h0;
        end
      end
      ST_DATA: begin
        if (tick && s.phase == SAMPLE_LAST) begin
          n.shifter = {vote, s.shifter[8:1]}; // LSB first
        end
        if (tick && s.phase == PHASE_END) begin
          n.bitcnt = s.bitcnt + 4'h1;
          if (s.bitcnt == last_bit) begin
            n.state = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        // Finish at mid-stop so the next start edge is never missed
        if (tick && s.phase == SAMPLE_LAST) begin
          stop_done = 1'b1;
          n.state = ST_IDLE;
          new_word.framing_error = ~vote;
          if (s.count == FIFO_FULL) begin
            n.overrun_error = 1'b1; // word in the shifter is lost
          end else if (!s.overrun_error) begin
            push = 1'b1;
          end
        end
      end
    endcase

    // Register writes; status flags are not writable
    if (bus.wr) begin
      unique case (sel)
        SEL_BANK: n.bank = bus.wdata;
        SEL_STATUS: begin
          n.serial_port_enable = bus.wdata[RCS_SERIAL_PORT_ENABLE];
          n.rx9 = bus.wdata[RCS_RX9];
          n.single_receive_enable = bus.wdata[RCS_SINGLE_RECEIVE_ENABLE];
          n.continuous_receive_enable = bus.wdata[RCS_CONTINUOUS_RECEIVE_ENABLE];
        end
        SEL_BAUD: n.baud = bus.wdata;
        SEL_IRQ_EN: n.receive_interrupt_enable = bus.wdata[IE_RX];
        SEL_MODE: n.sync_mode = bus.wdata[MODE_SYNC];
        default: ;
      endcase
    end

    // Read data; reading the data location pops the FIFO
    // An empty FIFO read returns the stale head and leaves it in place
    pop = bus.rd && sel == SEL_DATA && s.count != 2'h0;
    if (bus.rd) begin
      n.rd_data = 8'h00;
      unique case (sel)
        SEL_BANK: n.rd_data = s.bank;
        SEL_STATUS: begin
          n.rd_data[RCS_SERIAL_PORT_ENABLE] = s.serial_port_enable;
          n.rd_data[RCS_RX9] = s.rx9;
          n.rd_data[RCS_SINGLE_RECEIVE_ENABLE] = s.single_receive_enable;
          n.rd_data[RCS_CONTINUOUS_RECEIVE_ENABLE] = s.continuous_receive_enable;
          n.rd_data[RCS_FRAMING_ERROR] = head_word.framing_error;
          n.rd_data[RCS_OVERRUN_ERROR] = s.overrun_error;
          n.rd_data[RCS_NINTH_RECEIVED_BIT] = head_word.ninth;
        end
        SEL_DATA: n.rd_data = head_word.data;
        SEL_FLAGS: n.rd_data[FLAG_RX] = (s.count != 2'h0);
        SEL_BAUD: n.rd_data = s.baud;
        SEL_IRQ_EN: n.rd_data[IE_RX] = s.receive_interrupt_enable;
        SEL_MODE: n.rd_data[MODE_SYNC] = s.sync_mode;
        default: ;
      endcase
    end

    // FIFO update; the tail is head plus occupancy
    if (push) begin
      n.fifo[s.head ^ s.count[0]] = new_word;
    end
    if (pop) begin
      n.head = ~s.head;
    end
    n.count = s.count + {1'b0, push} - {1'b0, pop};

    // Terminating reception returns the receiver to idle, overrun cleared
    if (!rx_keep) begin
      n.state = ST_IDLE;
      n.overrun_error = 1'b0;
      n.bitcnt = 4'h0;
    end

    // Interrupt is simply FIFO not empty, gated by its enable
    n.irq = (n.count != 2'h0) & n.receive_interrupt_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.bank <= RST_BANK;
      s.baud <= RST_BAUD;
      s.div <= RST_BAUD;
      s.sync_mode <= RST_MODE[MODE_SYNC];
      s.rd_data <= RST_RD_DATA;
      s.rx_prev <= 1'b1;
      s.state <= ST_IDLE;
    end else begin
      s <= n;
    end
  end

  assign rd_data = s.rd_data;
  assign rx_irq = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  start_align_a: assert property (
    (s.state == ST_IDLE && rx_run && rx_keep && s.rx_prev && !serial_input_pin)
      |=> (s.state == ST_START && s.phase == 4'h0))
    else $error("start edge did not realign oversampling");

  enable_gate_a: assert property (
    (s.state == ST_IDLE && !rx_run) |=> s.state == ST_IDLE)
    else $error("reception began without continuous enable");

  fifo_depth_a: assert property (
    s.count <= FIFO_FULL)
    else $error("fifo occupancy above two");

  fifo_order_a: assert property (
    (bus.rd && sel == SEL_DATA && s.count == FIFO_FULL)
      |=> (rd_data == $past(s.fifo[s.head].data) && s.count == 2'h1 && s.head != $past(s.head)))
    else $error("fifo read out of order");

  irq_gate_a: assert property (
    rx_irq == ((s.count != 2'h0) && s.receive_interrupt_enable))
    else $error("interrupt does not follow flag and enable");

  overrun_set_a: assert property (
    (stop_done && s.count == FIFO_FULL && rx_keep && !pop) |=> (s.overrun_error && s.count == $past(s.count)))
    else $error("overrun not flagged on full fifo");

  overrun_block_a: assert property (
    (s.overrun_error && !pop) |=> s.count == $past(s.count))
    else $error("word entered fifo during overrun");

  framing_a: assert property (
    (stop_done && s.count == 2'h0 && !s.overrun_error && !pop)
      |=> s.fifo[s.head].framing_error == !$past(vote))
    else $error("framing error not stored with word");

  terminate_a: assert property (
    !rx_keep |=> (s.state == ST_IDLE && !s.overrun_error))
    else $error("terminate did not reset receiver");

  sample_rate_a: assert property (
    (tick && s.state != ST_IDLE) |=> (s.phase == $past(s.phase) + 4'h1 || s.state == ST_IDLE))
    else $error("oversampling phase skipped");

  // Further checks on FIFO, register readback, interrupt, mode and sampling
  push_count_a: assert property (
    (push && !pop) |=> s.count == $past(s.count) + 2'h1)
    else $error("pushed word not counted");

  pop_drain_a: assert property (
    (pop && !push && s.count == 2'h1) |=> s.count == 2'h0)
    else $error("flag not cleared after last read");

  ninth_store_a: assert property (
    (push && !pop && s.count == 2'h0) |=> s.fifo[s.head].ninth == $past(s.rx9 && s.shifter[8]))
    else $error("ninth bit not stored with word");

  status_read_a: assert property (
    (bus.rd && sel == SEL_STATUS) |=> (rd_data[RCS_FRAMING_ERROR] == $past(head_word.framing_error) && rd_data[RCS_NINTH_RECEIVED_BIT] == $past(head_word.ninth)))
    else $error("status bits not from head word");

  bank_ignore_a: assert property (
    (bus.rd && bus.addr == OFS_BANK_SEL) |=> rd_data == $past(s.bank))
    else $error("bank selector read wrong");

  data_shift_a: assert property (
    (s.state == ST_DATA && !(tick && s.phase == SAMPLE_LAST)) |=> s.shifter == $past(s.shifter))
    else $error("shifter moved off bit centre");

  sample_take_a: assert property (
    (tick && s.phase == SAMPLE_FIRST) |=> s.smp[0] == $past(serial_input_pin))
    else $error("first sample not taken");

  overrun_hold_a: assert property (
    (s.overrun_error && rx_keep) |=> s.overrun_error)
    else $error("overrun cleared without terminate");

  start_glitch_a: assert property (
    (s.state == ST_START && tick && s.phase == SAMPLE_LAST && vote) |=> s.state == ST_IDLE)
    else $error("false start not rejected");

  stop_center_a: assert property (
    stop_done |-> (s.state == ST_STOP && tick && s.phase == SAMPLE_LAST))
    else $error("stop judged off centre");

  bit_count_a: assert property (
    (s.state == ST_DATA) |-> s.bitcnt <= LAST_BIT_9)
    else $error("data bit count overran");

  rd_hold_a: assert property (
    !bus.rd |=> $stable(rd_data))
    else $error("read data changed without read");

  irq_enable_a: assert property (
    !s.receive_interrupt_enable |-> !rx_irq)
    else $error("interrupt while disabled");

  mode_block_a: assert property (
    (s.sync_mode && s.state == ST_IDLE) |=> s.state == ST_IDLE)
    else $error("clocked mode started reception");

  flag_read_a: assert property (
    (bus.rd && sel == SEL_FLAGS) |=> rd_data[FLAG_RX] == ($past(s.count) != 2'h0))
    else $error("receive flag read wrong");

  data_read_a: assert property (
    (bus.rd && sel == SEL_DATA) |=> rd_data == $past(head_word.data))
    else $error("data read not head word");

endmodule : arsr_receiver
